// *** hw/exposure_shutter_timing.sv ***
// exposure shutter timing and gain selection with apb registers
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module exposure_shutter_timing
    import exposure_shutter_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        line_tick_i,
    input  wire logic        frame_start_i,
    input  wire logic        trigger_n_i,
    output logic             exposing_o,
    output logic             exposure_done_o,
    output logic [7:0]       manual_gain_o,
    output logic             automatic_gain_mode_o,
    output logic             manual_gain_mode_o
);
    // register file and table
    logic [15:0] table_r [PAGES][POSITIONS];
    logic [11:0] ctrl_r, ctrl_nxt;
    logic [7:0]  gain_r, gain_nxt;
    logic [15:0] direct_r, direct_nxt;
    logic        flag_r, flag_nxt;
    // frame-latched copies
    logic [11:0] act_ctrl_r, act_ctrl_nxt;
    logic [7:0]  act_gain_r, act_gain_nxt;
    logic        act_auto_r, act_auto_nxt;
    logic [15:0] act_len_r, act_len_nxt;
    // trigger synchroniser, line and frame from same clock
    logic        trig_s1_r, trig_s2_r, trig_d_r;
    exp_state_type state_r, state_nxt;
    logic [15:0] lines_r, lines_nxt;
    logic [15:0] frames_r, frames_nxt;
    logic [15:0] pulse_lines_r, pulse_lines_nxt;
    logic        done_r, done_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        err_r, err_nxt;
    logic        wr_en, acc;
    logic [3:0]  tab_page, tab_pos;
    logic        tab_hit;
    logic [31:0] tab_off;

    function automatic logic [15:0] hs_default(input logic [3:0] pos);
        case (pos)
            4'h1: hs_default = HS_DEFAULT_1;
            4'h2: hs_default = HS_DEFAULT_2;
            4'h3: hs_default = HS_DEFAULT_3;
            4'h4: hs_default = HS_DEFAULT_4;
            4'h5: hs_default = HS_DEFAULT_5;
            4'h6: hs_default = HS_DEFAULT_6;
            4'h7: hs_default = HS_DEFAULT_7;
            4'h8: hs_default = HS_DEFAULT_8;
            4'h9: hs_default = HS_DEFAULT_9;
            default: hs_default = FRAME_LINES;
        endcase
    endfunction : hs_default

    assign acc      = psel_i && penable_i;
    assign wr_en    = acc && pwrite_i;
    assign tab_off  = paddr_i - ADDR_TABLE;
    assign tab_page = tab_off[9:6];
    assign tab_pos  = tab_off[5:2];
    // table window: 10 words per page at a 16-word stride above the table base, position 0 read-only
    assign tab_hit  = (paddr_i >= ADDR_TABLE) && (tab_off[31:10] == 22'h00_0000)
                      && (tab_off[1:0] == 2'b00) && (32'(tab_page) < PAGES)
                      && (32'(tab_pos) < POSITIONS);
    assign pready_o = 1'b1;
    assign prdata_o = rdata_r;
    assign pslverr_o = err_r;

    always_comb
    begin
        ctrl_nxt   = ctrl_r;
        gain_nxt   = gain_r;
        direct_nxt = direct_r;
        flag_nxt   = flag_r;
        rdata_nxt  = rdata_r;
        err_nxt    = 1'b0;
        // read data and error are registered in the setup phase, so they stand in the access
        if (psel_i)
        begin
            rdata_nxt = 32'h0000_0000;
            if (paddr_i == ADDR_CTRL)
            begin
                rdata_nxt = {20'h0_0000, ctrl_r};
                if (wr_en)
                    ctrl_nxt = pwdata_i[11:0];
            end
            else if (paddr_i == ADDR_GAIN)
            begin
                rdata_nxt = {24'h00_0000, gain_r};
                if (wr_en)
                    gain_nxt = pwdata_i[7:0];
            end
            else if (paddr_i == ADDR_DIRECT)
            begin
                rdata_nxt = {16'h0000, direct_r};
                if (wr_en)
                    direct_nxt = pwdata_i[15:0];
            end
            else if (paddr_i == ADDR_FLAG)
            begin
                rdata_nxt = {31'h0000_0000, flag_r};
                if (wr_en)
                    flag_nxt = pwdata_i[FLAG_AUTO_GAIN];
            end
            else if (paddr_i == ADDR_STATUS)
                rdata_nxt = {12'h000, state_r, done_r, act_auto_r, act_len_r};
            else if (tab_hit)
                rdata_nxt = {16'h0000, table_r[tab_page[2:0]][tab_pos]};
            else
                err_nxt = !penable_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ctrl_r   <= 12'h000;
            gain_r   <= GAIN_RESET;
            direct_r <= 16'h0001;
            flag_r   <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            err_r    <= 1'b0;
        end
        else
        begin
            ctrl_r   <= ctrl_nxt;
            gain_r   <= gain_nxt;
            direct_r <= direct_nxt;
            flag_r   <= flag_nxt;
            rdata_r  <= rdata_nxt;
            err_r    <= err_nxt;
        end
    end

    // table: reset restores defaults, writes skip position 0
    always_ff @(posedge clock_i)
    begin
        for (int p = 0; p < PAGES; p++)
        begin
            for (int s = 0; s < POSITIONS; s++)
            begin
                if (srst_i)
                    table_r[p][s] <= hs_default(4'(s));
                else if (wr_en && tab_hit && tab_pos != 4'h0
                         && 32'(tab_page) == p && 32'(tab_pos) == s)
                    table_r[p][s] <= pwdata_i[15:0];
            end
        end
    end

    // settings taken at frame start only
    always_comb
    begin
        logic [3:0] pos;
        logic [2:0] pg;
        pos = ctrl_nxt[CTRL_POS_LSB +: 4];
        pg  = ctrl_nxt[CTRL_PAGE_LSB +: 3];
        act_ctrl_nxt = act_ctrl_r;
        act_gain_nxt = act_gain_r;
        act_auto_nxt = act_auto_r;
        act_len_nxt  = act_len_r;
        if (frame_start_i && state_r == ST_IDLE)
        begin
            act_ctrl_nxt = ctrl_r;
            act_gain_nxt = gain_r;
            act_auto_nxt = flag_r;
            pos = ctrl_r[CTRL_POS_LSB +: 4];
            pg  = ctrl_r[CTRL_PAGE_LSB +: 3];
            if (32'(pg) >= PAGES)
                pg = 3'h0;
            if (32'(pos) >= POSITIONS)
                pos = 4'h9;
            if (ctrl_r[CTRL_DIRECT])
                act_len_nxt = (direct_r == 16'h0000) ? 16'h0001 : direct_r;
            else if (pos == 4'h0)
                act_len_nxt = FRAME_LINES;
            else if (ctrl_r[CTRL_LOW_SPEED] && !ctrl_r[CTRL_ASYNC])
                act_len_nxt = 16'(pos) + LS_FRAMES_OFFSET;
            else
                act_len_nxt = table_r[pg][pos];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            act_ctrl_r <= 12'h000;
            act_gain_r <= GAIN_RESET;
            act_auto_r <= 1'b0;
            act_len_r  <= FRAME_LINES;
        end
        else
        begin
            act_ctrl_r <= act_ctrl_nxt;
            act_gain_r <= act_gain_nxt;
            act_auto_r <= act_auto_nxt;
            act_len_r  <= act_len_nxt;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            trig_s1_r <= 1'b1;
            trig_s2_r <= 1'b1;
            trig_d_r  <= 1'b1;
        end
        else
        begin
            trig_s1_r <= trigger_n_i;
            trig_s2_r <= trig_s1_r;
            trig_d_r  <= trig_s2_r;
        end
    end

    // exposure sequencer; low speed counts frames unless async, direct or position 0, others count lines
    always_comb
    begin
        logic low_mode;
        logic pulse_mode;
        logic fall;
        low_mode = act_ctrl_r[CTRL_LOW_SPEED] && !act_ctrl_r[CTRL_ASYNC]
                   && !act_ctrl_r[CTRL_DIRECT]
                   && act_ctrl_r[CTRL_POS_LSB +: 4] != 4'h0;
        pulse_mode = act_ctrl_r[CTRL_ASYNC] && act_ctrl_r[CTRL_PULSE] && !act_ctrl_r[CTRL_DIRECT]
                   && act_ctrl_r[CTRL_POS_LSB +: 4] == PULSE_POSITION;
        fall = trig_d_r && !trig_s2_r;
        state_nxt       = state_r;
        lines_nxt       = lines_r;
        frames_nxt      = frames_r;
        pulse_lines_nxt = pulse_lines_r;
        done_nxt        = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                lines_nxt  = 16'h0000;
                frames_nxt = 16'h0000;
                pulse_lines_nxt = 16'h0000;
                if (pulse_mode && fall)
                    state_nxt = ST_PULSE;
                else if (act_ctrl_r[CTRL_ASYNC] && !pulse_mode && fall)
                    state_nxt = ST_EXPOSE;
                else if (!act_ctrl_r[CTRL_ASYNC] && frame_start_i)
                    state_nxt = ST_EXPOSE;
            end
            ST_EXPOSE:
            begin
                if (low_mode)
                begin
                    if (frame_start_i)
                        frames_nxt = frames_r + 16'h0001;
                    if (frame_start_i && frames_r + 16'h0001 >= act_len_r)
                    begin
                        state_nxt = ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
                else
                begin
                    if (line_tick_i)
                        lines_nxt = lines_r + 16'h0001;
                    if (line_tick_i && lines_r + 16'h0001 >= act_len_r)
                    begin
                        state_nxt = ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
            end
            ST_PULSE:
            begin
                if (line_tick_i && !trig_s2_r)
                    pulse_lines_nxt = pulse_lines_r + 16'h0001;
                // ends on release once at least one line has passed
                if (trig_s2_r && pulse_lines_r != 16'h0000)
                begin
                    state_nxt = ST_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_r       <= ST_IDLE;
            lines_r       <= 16'h0000;
            frames_r      <= 16'h0000;
            pulse_lines_r <= 16'h0000;
            done_r        <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            lines_r       <= lines_nxt;
            frames_r      <= frames_nxt;
            pulse_lines_r <= pulse_lines_nxt;
            done_r        <= done_nxt;
        end
    end

    assign exposing_o            = (state_r != ST_IDLE);
    assign exposure_done_o       = done_r;
    assign manual_gain_o         = act_gain_r;
    assign automatic_gain_mode_o = act_auto_r;
    assign manual_gain_mode_o    = !act_auto_r;
endmodule : exposure_shutter_timing
`default_nettype wire

// *** hw/exposure_shutter_pkg.sv ***
// constants and types for the exposure shutter timing block
`default_nettype none
package exposure_shutter_pkg;
    localparam int           PAGES       = 6;
    localparam int           POSITIONS   = 10;
    localparam logic [15:0]  FRAME_LINES = 16'h042c;
    localparam logic [15:0]  HS_DEFAULT_1 = 16'h0001;
    localparam logic [15:0]  HS_DEFAULT_2 = 16'h0003;
    localparam logic [15:0]  HS_DEFAULT_3 = 16'h0008;
    localparam logic [15:0]  HS_DEFAULT_4 = 16'h0010;
    localparam logic [15:0]  HS_DEFAULT_5 = 16'h0021;
    localparam logic [15:0]  HS_DEFAULT_6 = 16'h0043;
    localparam logic [15:0]  HS_DEFAULT_7 = 16'h0086;
    localparam logic [15:0]  HS_DEFAULT_8 = 16'h0117;
    localparam logic [15:0]  HS_DEFAULT_9 = 16'h0215;
    localparam logic [15:0]  LS_FRAMES_OFFSET = 16'h0001;
    localparam logic [3:0]   PULSE_POSITION = 4'h9;
    localparam logic [7:0]   GAIN_RESET  = 8'h00;
    localparam logic [31:0]  ADDR_CTRL   = 32'h0000_0000;
    localparam logic [31:0]  ADDR_GAIN   = 32'h0000_0004;
    localparam logic [31:0]  ADDR_DIRECT = 32'h0000_0008;
    localparam logic [31:0]  ADDR_FLAG   = 32'h0000_000c;
    localparam logic [31:0]  ADDR_STATUS = 32'h0000_0010;
    localparam logic [31:0]  ADDR_TABLE  = 32'h0000_0100;
    localparam int CTRL_POS_LSB   = 0;
    localparam int CTRL_PAGE_LSB  = 4;
    localparam int CTRL_ASYNC     = 8;
    localparam int CTRL_LOW_SPEED = 9;
    localparam int CTRL_PULSE     = 10;
    localparam int CTRL_DIRECT    = 11;
    localparam int FLAG_AUTO_GAIN = 0;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EXPOSE = 2'b01,
        ST_PULSE  = 2'b10
    } exp_state_type;
endpackage : exposure_shutter_pkg
`default_nettype wire

// *** tb/exposure_shutter_timing_checker.sv ***
// port-level assertions for the exposure shutter timing block
`timescale 1ns/1ps
`default_nettype none
module exposure_shutter_checker
(
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    input wire logic        line_tick_i,
    input wire logic        frame_start_i,
    input wire logic        trigger_n_i,
    input wire logic        exposing_o,
    input wire logic        exposure_done_o,
    input wire logic [7:0]  manual_gain_o,
    input wire logic        automatic_gain_mode_o,
    input wire logic        manual_gain_mode_o
);
    default clocking dcb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    mode_excl_a: assert property (automatic_gain_mode_o != manual_gain_mode_o)
        else $error("gain modes not exclusive");
    gain_hold_a: assert property ($changed(manual_gain_o) |-> $past(frame_start_i))
        else $error("gain code moved away from a frame start");
    auto_hold_a: assert property (!$past(frame_start_i) |-> $stable(automatic_gain_mode_o))
        else $error("auto gain moved away from a frame start");
    done_end_a: assert property (exposure_done_o |-> !exposing_o && $past(exposing_o))
        else $error("done without a finished exposure");
    done_single_a: assert property (exposure_done_o |=> !exposure_done_o)
        else $error("done longer than one cycle");
    end_cause_a: assert property ($fell(exposing_o) |->
        $past(line_tick_i) || $past(frame_start_i) || $past(trigger_n_i))
        else $error("exposure ended without a cause");
    err_cause_a: assert property (pslverr_o |-> $past(psel_i && !penable_i))
        else $error("error without an access");
    rdata_hold_a: assert property (!$past(psel_i) |-> $stable(prdata_o))
        else $error("read data moved without an access");
endmodule : exposure_shutter_checker

bind exposure_shutter_timing exposure_shutter_checker chk (.clock_i(clock_i), .srst_i(srst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .line_tick_i(line_tick_i), .frame_start_i(frame_start_i), .trigger_n_i(trigger_n_i),
    .exposing_o(exposing_o), .exposure_done_o(exposure_done_o), .manual_gain_o(manual_gain_o),
    .automatic_gain_mode_o(automatic_gain_mode_o), .manual_gain_mode_o(manual_gain_mode_o));
`default_nettype wire

// *** tb/test_exposure_shutter_timing.sv ***
// self-checking bench for the exposure shutter timing block
`timescale 1ns/1ps
`default_nettype none
module test_exposure_shutter_timing;
    import exposure_shutter_pkg::*;
    logic        clock_i       = 1'b0;
    logic        srst_i        = 1'b1;
    logic        psel_i        = 1'b0;
    logic        penable_i     = 1'b0;
    logic        pwrite_i      = 1'b0;
    logic [31:0] paddr_i       = 32'h0000_0000;
    logic [31:0] pwdata_i      = 32'h0000_0000;
    logic        line_tick_i   = 1'b0;
    logic        frame_start_i = 1'b0;
    logic        trigger_n_i   = 1'b1;
    logic        pready_o, pslverr_o, exposing_o, exposure_done_o;
    logic        automatic_gain_mode_o, manual_gain_mode_o;
    logic [31:0] prdata_o;
    logic [7:0]  manual_gain_o;
    logic [31:0] rd;
    logic        err;
    logic        dn;
    int          n;
    int          mismatches  = 0;
    int          check_count = 0;
    logic [15:0] hs [10] = '{16'h042c, 16'h0001, 16'h0003, 16'h0008, 16'h0010,
                             16'h0021, 16'h0043, 16'h0086, 16'h0117, 16'h0215};

    always #5 clock_i = ~clock_i;

    exposure_shutter_timing dut (.clock_i(clock_i), .srst_i(srst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .line_tick_i(line_tick_i), .frame_start_i(frame_start_i), .trigger_n_i(trigger_n_i),
        .exposing_o(exposing_o), .exposure_done_o(exposure_done_o),
        .manual_gain_o(manual_gain_o), .automatic_gain_mode_o(automatic_gain_mode_o),
        .manual_gain_mode_o(manual_gain_mode_o));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // read data and error are taken at the edge that ends the access, then one idle cycle
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do
            @(posedge clock_i);
        while (pready_o !== 1'b1);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask : apb

    task automatic step(input logic tick, input logic frame, output logic done);
        line_tick_i   <= tick;
        frame_start_i <= frame;
        @(posedge clock_i);
        line_tick_i   <= 1'b0;
        frame_start_i <= 1'b0;
        @(negedge clock_i);
        done = exposure_done_o;
        @(posedge clock_i);
    endtask : step

    function automatic logic [31:0] cfg(int pos, int pg, int asy, int lo, int pw, int di);
        return (32'(pos) << CTRL_POS_LSB) | (32'(pg) << CTRL_PAGE_LSB) | (32'(asy) << CTRL_ASYNC)
            | (32'(lo) << CTRL_LOW_SPEED) | (32'(pw) << CTRL_PULSE) | (32'(di) << CTRL_DIRECT);
    endfunction : cfg

    // the latching frame start is gated by the old setting but exposes with the new one, so that exposure is finished first
    task automatic setcfg(input logic [31:0] c, input logic running);
        logic d;
        apb(1'b1, ADDR_CTRL, c);
        step(1'b0, 1'b1, d);
        for (int k = 0; k < 1200 && running && d !== 1'b1; k++)
            step(1'b1, k % 4 == 3, d);
        if (running && d !== 1'b1)
            mismatches++;
    endtask : setcfg

    // mode 0 counts lines, 1 counts frames, 2 starts on the trigger and counts lines
    task automatic measure(input int mode, output int cnt);
        logic d;
        cnt = 0;
        d   = 1'b0;
        if (mode == 2)
        begin
            trigger_n_i <= 1'b0;
            repeat (3) @(posedge clock_i);
            trigger_n_i <= 1'b1;
            repeat (6) @(posedge clock_i);
        end
        else
            step(1'b0, 1'b1, d);
        while (d !== 1'b1 && cnt < 1100)
        begin
            step(mode != 1, mode == 1, d);
            cnt++;
        end
    endtask : measure

    initial
    begin
        repeat (12) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        check({23'h0, automatic_gain_mode_o, manual_gain_o}, 32'h0000_0000);
        for (int p = 0; p < PAGES; p++)
            for (int s = 0; s < POSITIONS; s++)
            begin
                apb(1'b0, ADDR_TABLE + 32'(p * 64 + s * 4), 32'h0000_0000);
                check(rd, {16'h0000, hs[s]});
            end
        apb(1'b1, 32'h0000_018c, 32'h0000_0005);
        apb(1'b1, 32'h0000_0180, 32'h0000_0007);
        check({31'h0, err}, 32'h0000_0000);
        apb(1'b0, 32'h0000_0180, 32'h0000_0000);
        check(rd, 32'h0000_042c);
        apb(1'b0, 32'h0000_01cc, 32'h0000_0000);
        check(rd, 32'h0000_0008);
        apb(1'b0, 32'h0000_0ffc, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, ADDR_GAIN, 32'h0000_00ff);
        apb(1'b1, ADDR_FLAG, 32'h0000_0001);
        check({23'h0, automatic_gain_mode_o, manual_gain_o}, 32'h0000_0000);
        setcfg(cfg(1, 0, 0, 0, 0, 0), 1'b1);
        check({23'h0, automatic_gain_mode_o, manual_gain_o}, 32'h0000_01ff);
        check({31'h0, manual_gain_mode_o}, 32'h0000_0000);
        apb(1'b1, ADDR_FLAG, 32'h0000_0000);
        for (int s = 0; s < POSITIONS; s++)
        begin
            setcfg(cfg(s, 0, 0, 0, 0, 0), 1'b1);
            measure(0, n);
            check(32'(n), {16'h0000, hs[s]});
        end
        for (int s = 1; s < POSITIONS; s++)
        begin
            setcfg(cfg(s, 0, 0, 1, 0, 0), 1'b1);
            measure(1, n);
            check(32'(n), 32'(s + 1));
        end
        setcfg(cfg(3, 2, 0, 0, 0, 0), 1'b1);
        measure(0, n);
        check(32'(n), 32'h0000_0005);
        apb(1'b1, ADDR_DIRECT, 32'h0000_0002);
        setcfg(cfg(3, 2, 0, 0, 0, 1), 1'b1);
        measure(0, n);
        check(32'(n), 32'h0000_0002);
        setcfg(cfg(9, 0, 1, 0, 0, 0), 1'b1);
        measure(2, n);
        check(32'(n), 32'h0000_0215);
        setcfg(cfg(2, 0, 1, 1, 0, 0), 1'b0);
        measure(2, n);
        check(32'(n), 32'h0000_0003);
        setcfg(cfg(9, 0, 1, 0, 1, 0), 1'b0);
        trigger_n_i <= 1'b0;
        n = 0;
        // longer than the preset at position 9, so only the pulse may end it
        repeat (600)
        begin
            step(1'b1, 1'b0, dn);
            if (dn !== 1'b0)
                n++;
        end
        check(32'(n), 32'h0000_0000);
        check({31'h0, exposing_o}, 32'h0000_0001);
        trigger_n_i <= 1'b1;
        dn = 1'b0;
        for (int k = 0; k < 20 && dn !== 1'b1; k++)
        begin
            @(negedge clock_i);
            dn = exposure_done_o;
        end
        check({31'h0, dn}, 32'h0000_0001);
        end_sim();
    end

    initial
    begin
        #300_000;
        mismatches++;
        end_sim();
    end
endmodule : test_exposure_shutter_timing
`default_nettype wire
